// ### logic/emc_ctrl.sv
// Camera controller end: drives exposure pins and register port.
// Assumes the user issues one command per cycle at most.
`timescale 1ns/10ps
module emc_ctrl (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  // User register port
  input wire logic [7:0] u_addr,
  input wire logic [7:0] u_wdata,
  input wire logic u_wr,
  input wire logic u_rd,
  output logic [7:0] u_rdata,
  // User pin levels
  input wire logic u_pin_a,
  input wire logic u_pin_b,
  input wire logic u_frame_req,
  // Link
  emc_if.ctrl link
);
  logic [7:0] addr_reg, addr_next, wdata_reg, wdata_next;
  logic wr_reg, wr_next, rd_reg, rd_next;
  logic a_reg, a_next, b_reg, b_next, f_reg, f_next;
  logic [7:0] rdata_reg, rdata_next;
  logic rd_q_reg, rd_q_next;

  always_comb begin
    addr_next = u_addr;
    wdata_next = u_wdata;
    wr_next = u_wr;
    rd_next = u_rd & ~u_wr;
    // Pins pass straight; edges one cycle apart are legal
    a_next = u_pin_a;
    b_next = u_pin_b;
    f_next = u_frame_req;
    rd_q_next = rd_reg;
    rdata_next = rd_q_reg ? link.reg_rdata : rdata_reg;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      addr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      a_reg <= 1'b0;
      b_reg <= 1'b0;
      f_reg <= 1'b0;
      rd_q_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else if (clk_en) begin
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      a_reg <= a_next;
      b_reg <= b_next;
      f_reg <= f_next;
      rd_q_reg <= rd_q_next;
      rdata_reg <= rdata_next;
    end
  end

  assign link.reg_addr = addr_reg;
  assign link.reg_wdata = wdata_reg;
  assign link.reg_wr = wr_reg;
  assign link.reg_rd = rd_reg;
  assign link.exposure_pin_a = a_reg;
  assign link.exposure_pin_b = b_reg;
  assign link.frame_req = f_reg;
  assign u_rdata = rdata_reg;
endmodule : emc_ctrl

// ### logic/emc_sensor.sv
// Sensor end: exposure configuration registers and exposure timing.
// Assumes pins and register port are synchronous to ref_clk.
`timescale 1ns/10ps
module emc_sensor (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Link
  emc_if.sensor link,
  // Status
  output logic exposing_even,
  output logic exposing_odd,
  output logic [31:0] even_cycles,
  output logic [31:0] odd_cycles,
  output logic done
);
  logic [7:0] mode_reg, mode_next;
  logic [7:0] colour_reg, colour_next;
  logic [7:0] fot_reg, fot_next;
  logic [23:0] exp_reg, exp_next;
  logic [23:0] odd_reg, odd_next;
  logic [7:0] rdata_reg, rdata_next;
  logic a_q_reg, a_q_next, b_q_reg, b_q_next, f_q_reg, f_q_next;
  logic ev_reg, ev_next, od_reg, od_next, done_reg, done_next;
  logic [31:0] ecnt_reg, ecnt_next, ocnt_reg, ocnt_next;
  logic [31:0] etot_reg, etot_next, otot_reg, otot_next;
  logic [31:0] ovh;
  logic a_rise, b_rise, f_rise, ext, dual;

  assign ext = mode_reg[emc_pkg::MODE_EXT_BIT];
  assign dual = mode_reg[emc_pkg::MODE_DUAL_BIT];
  // Overhead cycles from the fot register, 129*0.43*fot
  assign ovh = 32'((emc_pkg::UNIT_CYCLES * emc_pkg::FOT_NUM
    * int'(fot_reg)) / emc_pkg::FOT_DEN);
  assign a_rise = link.exposure_pin_a & ~a_q_reg;
  assign b_rise = link.exposure_pin_b & ~b_q_reg;
  assign f_rise = link.frame_req & ~f_q_reg;

  always_comb begin
    mode_next = mode_reg;
    colour_next = colour_reg;
    fot_next = fot_reg;
    exp_next = exp_reg;
    odd_next = odd_reg;
    rdata_next = 8'h00;
    if (link.reg_wr) begin
      unique case (link.reg_addr)
        emc_pkg::ADDR_MODE: mode_next = link.reg_wdata;
        emc_pkg::ADDR_COLOUR: colour_next = link.reg_wdata;
        emc_pkg::ADDR_FOT: fot_next = link.reg_wdata;
        emc_pkg::ADDR_EXP0: exp_next[7:0] = link.reg_wdata;
        emc_pkg::ADDR_EXP1: exp_next[15:8] = link.reg_wdata;
        emc_pkg::ADDR_EXP2: exp_next[23:16] = link.reg_wdata;
        emc_pkg::ADDR_ODD0: odd_next[7:0] = link.reg_wdata;
        emc_pkg::ADDR_ODD1: odd_next[15:8] = link.reg_wdata;
        emc_pkg::ADDR_ODD2: odd_next[23:16] = link.reg_wdata;
        default: ;
      endcase
    end
    if (link.reg_rd) begin
      unique case (link.reg_addr)
        emc_pkg::ADDR_MODE: rdata_next = mode_reg;
        emc_pkg::ADDR_COLOUR: rdata_next = colour_reg;
        emc_pkg::ADDR_FOT: rdata_next = fot_reg;
        emc_pkg::ADDR_EXP0: rdata_next = exp_reg[7:0];
        emc_pkg::ADDR_EXP1: rdata_next = exp_reg[15:8];
        emc_pkg::ADDR_EXP2: rdata_next = exp_reg[23:16];
        emc_pkg::ADDR_ODD0: rdata_next = odd_reg[7:0];
        emc_pkg::ADDR_ODD1: rdata_next = odd_reg[15:8];
        emc_pkg::ADDR_ODD2: rdata_next = odd_reg[23:16];
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Exposure timing
  always_comb begin
    a_q_next = link.exposure_pin_a;
    b_q_next = link.exposure_pin_b;
    f_q_next = link.frame_req;
    ev_next = ev_reg;
    od_next = od_reg;
    ecnt_next = ecnt_reg;
    ocnt_next = ocnt_reg;
    etot_next = etot_reg;
    otot_next = otot_reg;
    done_next = 1'b0;
    if (ext) begin
      // Pin a opens even rows (and odd rows unless dual), pin b opens odd rows in dual mode, frame_req closes
      if (ev_reg) ecnt_next = ecnt_reg + 32'h1;
      if (od_reg) ocnt_next = ocnt_reg + 32'h1;
      if (a_rise && !f_rise) begin
        ev_next = 1'b1;
        ecnt_next = 32'h1;
        if (!dual) begin
          od_next = 1'b1;
          ocnt_next = 32'h1;
        end
      end
      if (b_rise && dual && !f_rise) begin
        od_next = 1'b1;
        ocnt_next = 32'h1;
      end
      if (f_rise && ev_reg) begin
        ev_next = 1'b0;
        od_next = 1'b0;
        done_next = 1'b1;
        etot_next = ovh + ecnt_reg;
        otot_next = ovh + (od_reg ? ocnt_reg : ecnt_reg);
      end
    end else begin
      ev_next = 1'b0;
      od_next = 1'b0;
      // Internal: counts below the minimum of 1 are treated as 1
      etot_next = ovh + emc_pkg::UNIT_CYCLES
        * 32'((exp_reg < emc_pkg::EXP_MIN) ? emc_pkg::EXP_MIN
        : exp_reg);
      otot_next = ovh + emc_pkg::UNIT_CYCLES
        * 32'(dual ? ((odd_reg < emc_pkg::EXP_MIN) ? emc_pkg::EXP_MIN
        : odd_reg) : ((exp_reg < emc_pkg::EXP_MIN) ? emc_pkg::EXP_MIN
        : exp_reg));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode_reg <= emc_pkg::MODE_RESET;
      colour_reg <= emc_pkg::COLOUR_RESET;
      fot_reg <= emc_pkg::FOT_RESET;
      exp_reg <= emc_pkg::EXP_RESET;
      odd_reg <= emc_pkg::EXP_RESET;
      rdata_reg <= 8'h00;
      a_q_reg <= 1'b0;
      b_q_reg <= 1'b0;
      f_q_reg <= 1'b0;
      ev_reg <= 1'b0;
      od_reg <= 1'b0;
      done_reg <= 1'b0;
      ecnt_reg <= 32'h0;
      ocnt_reg <= 32'h0;
      etot_reg <= 32'h0;
      otot_reg <= 32'h0;
    end else if (clk_en) begin
      mode_reg <= mode_next;
      colour_reg <= colour_next;
      fot_reg <= fot_next;
      exp_reg <= exp_next;
      odd_reg <= odd_next;
      rdata_reg <= rdata_next;
      a_q_reg <= a_q_next;
      b_q_reg <= b_q_next;
      f_q_reg <= f_q_next;
      ev_reg <= ev_next;
      od_reg <= od_next;
      done_reg <= done_next;
      ecnt_reg <= ecnt_next;
      ocnt_reg <= ocnt_next;
      etot_reg <= etot_next;
      otot_reg <= otot_next;
    end
  end

  assign link.reg_rdata = rdata_reg;
  assign exposing_even = ev_reg;
  assign exposing_odd = od_reg;
  assign even_cycles = etot_reg;
  assign odd_cycles = otot_reg;
  assign done = done_reg;
endmodule : emc_sensor

// ### pkg/emc_if.sv
// Interface joining the camera controller and the sensor exposure logic.
// Assumes both ends share ref_clk; register port is byte wide.
`timescale 1ns/10ps
interface emc_if;
  logic exposure_pin_a;
  logic exposure_pin_b;
  logic frame_req;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  modport sensor (input exposure_pin_a, exposure_pin_b, frame_req,
    reg_addr, reg_wdata, reg_wr, reg_rd, output reg_rdata);
  modport ctrl (output exposure_pin_a, exposure_pin_b, frame_req,
    reg_addr, reg_wdata, reg_wr, reg_rd, input reg_rdata);
endinterface : emc_if

// ### pkg/emc_pkg.sv
// Package for the exposure mode control block: register map, resets,
// Timing constants. Assumes a byte-wide register port on the sensor side.
package emc_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_COLOUR = 8'h27;
  localparam logic [7:0] ADDR_MODE = 8'h29;
  localparam logic [7:0] ADDR_EXP0 = 8'h2a;
  localparam logic [7:0] ADDR_EXP1 = 8'h2b;
  localparam logic [7:0] ADDR_EXP2 = 8'h2c;
  localparam logic [7:0] ADDR_FOT = 8'h49;
  localparam logic [7:0] ADDR_ODD0 = 8'h38;
  localparam logic [7:0] ADDR_ODD1 = 8'h39;
  localparam logic [7:0] ADDR_ODD2 = 8'h3a;
  // Field positions
  localparam int MODE_EXT_BIT = 0;
  localparam int MODE_DUAL_BIT = 1;
  localparam int MONO_BIT = 0;
  // Reset values, minimum exposure count and short overhead value
  localparam logic [23:0] EXP_RESET = 24'h000440;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] COLOUR_RESET = 8'h01;
  localparam logic [7:0] FOT_RESET = 8'h0a;
  localparam logic [23:0] EXP_MIN = 24'h000001;
  localparam logic [7:0] FOT_SHORT = 8'h05;
  // Time base: one exposure unit is 129 clock periods
  localparam int UNIT_CYCLES = 129;
  // Overhead factor 0.43 as 43/100
  localparam int FOT_NUM = 43;
  localparam int FOT_DEN = 100;
endpackage : emc_pkg

// ### test/emc_sva.sv
// Checker on the register side of the link between the two ends.
// Assumes clk_en never freezes a register strobe high.
`timescale 1ns/10ps
module emc_sva (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Link
  input wire logic frame_req,
  input wire logic exposure_pin_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Shadow of every byte written, starting from the reset values
  logic [7:0] sh_reg [256];
  logic [7:0] sh_next [256];
  logic [7:0] exp_reg;
  logic [7:0] adr_reg;
  logic rd_reg;
  always_comb begin
    sh_next = sh_reg;
    if (reg_wr) sh_next[reg_addr] = reg_wdata;
  end
  always_ff @(posedge ref_clk) begin
    rd_reg <= reg_rd && !reset;
    adr_reg <= reg_addr;
    exp_reg <= sh_reg[reg_addr];
    if (reset) begin
      sh_reg <= '{default: 8'h00};
      sh_reg[8'h27] <= 8'h01;
      sh_reg[8'h2a] <= 8'h40;
      sh_reg[8'h2b] <= 8'h04;
      sh_reg[8'h38] <= 8'h40;
      sh_reg[8'h39] <= 8'h04;
      sh_reg[8'h49] <= 8'h0a;
    end else begin
      sh_reg <= sh_next;
    end
  end
  property p_rd(a);
    rd_reg && adr_reg == a |-> reg_rdata == exp_reg;
  endproperty
  chk_mode_read: assert property (p_rd(8'h29))
    else $error("mode byte read wrong");
  chk_colour_read: assert property (p_rd(8'h27))
    else $error("colour byte read wrong");
  chk_fot_read: assert property (p_rd(8'h49))
    else $error("overhead byte read wrong");
  chk_count_low: assert property (p_rd(8'h2a))
    else $error("count low byte read wrong");
  chk_count_high: assert property (p_rd(8'h2c))
    else $error("count high byte read wrong");
  chk_odd_count: assert property (p_rd(8'h38))
    else $error("odd count read wrong");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  chk_unmapped_zero: assert property (reg_rd && reg_addr == 8'h50
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  cover property (reg_wr && reg_addr == 8'h29);
  cover property ($rose(frame_req));
  cover property ($rose(exposure_pin_b));
endmodule : emc_sva

// ### test/tb_top.sv
// Bench: controller end and sensor end joined by emc_if.
// Assumes clk_en is dropped only by the freeze scenario.
`timescale 1ns/10ps
module tb_top;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic [7:0] u_addr = 8'h00;
  logic [7:0] u_wdata = 8'h00;
  logic u_wr = 1'b0;
  logic u_rd = 1'b0;
  logic u_pin_a = 1'b0;
  logic u_pin_b = 1'b0;
  logic u_frame_req = 1'b0;
  logic [7:0] u_rdata;
  logic exposing_even;
  logic exposing_odd;
  logic [31:0] even_cycles;
  logic [31:0] odd_cycles;
  logic done;
  int n_fail = 0;
  int samples_checked = 0;
  emc_if link ();
  emc_ctrl u_emc_ctrl (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
    .u_addr(u_addr), .u_wdata(u_wdata), .u_wr(u_wr), .u_rd(u_rd),
    .u_rdata(u_rdata), .u_pin_a(u_pin_a), .u_pin_b(u_pin_b),
    .u_frame_req(u_frame_req), .link(link));
  emc_sensor u_emc_sensor (.ref_clk(ref_clk), .reset(reset),
    .clk_en(clk_en), .link(link), .exposing_even(exposing_even),
    .exposing_odd(exposing_odd), .even_cycles(even_cycles),
    .odd_cycles(odd_cycles), .done(done));
  emc_sva u_emc_sva (.ref_clk(ref_clk), .reset(reset),
    .frame_req(link.frame_req), .exposure_pin_b(link.exposure_pin_b),
    .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
    .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .reg_rdata(link.reg_rdata));
  initial forever #5 ref_clk = ~ref_clk;
  function automatic logic [31:0] ovh(input int f);
    return 32'(129 * 43 * f / 100);
  endfunction : ovh
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp8
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp32
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_addr <= a;
    u_wdata <= d;
    u_wr <= 1'b1;
    @(posedge ref_clk);
    u_wr <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : wr
  // Read data reaches u_rdata three edges after the strobe and is held
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    u_addr <= a;
    u_rd <= 1'b1;
    @(posedge ref_clk);
    u_rd <= 1'b0;
    repeat (4) @(posedge ref_clk);
    cmp8(u_rdata, e);
  endtask : rd
  // Pin a rises, pin b gb cycles later, frame request gf cycles after a
  task automatic ext(input int gb, input int gf, input logic [31:0] ee,
    input logic [31:0] eo);
    int i;
    logic [1:0] seen;
    seen = 2'b00;
    u_pin_a <= 1'b1;
    repeat (gb) @(posedge ref_clk);
    u_pin_b <= 1'b1;
    repeat (gf - gb) @(posedge ref_clk);
    u_frame_req <= 1'b1;
    for (i = 0; i < 20 && done !== 1'b1; i++) begin
      seen = seen | {exposing_odd === 1'b1, exposing_even === 1'b1};
      @(posedge ref_clk);
    end
    if (done !== 1'b1) begin
      n_fail++;
      conclude();
    end else begin
      cmp32(even_cycles, ee);
      cmp32(odd_cycles, eo);
      cmp8({6'h00, seen}, 8'h03);
      cmp8({6'h00, exposing_odd, exposing_even}, 8'h00);
      u_pin_a <= 1'b0;
      u_pin_b <= 1'b0;
      u_frame_req <= 1'b0;
      @(posedge ref_clk);
    end
  endtask : ext
  task automatic t_reset;
    rd(8'h27, 8'h01);
    rd(8'h29, 8'h00);
    rd(8'h2a, 8'h40);
    rd(8'h3a, 8'h00);
    rd(8'h49, 8'h0a);
    rd(8'h50, 8'h00);
    cmp32(even_cycles, ovh(10) + 32'(129 * 1088));
  endtask : t_reset
  task automatic t_internal;
    wr(8'h49, 8'h05);
    wr(8'h2a, 8'h01);
    wr(8'h2b, 8'h01);
    wr(8'h2c, 8'h00);
    rd(8'h2c, 8'h00);
    cmp32(even_cycles, ovh(5) + 32'(129 * 257));
    wr(8'h2b, 8'h00);
    cmp32(even_cycles, ovh(5) + 32'd129);
    wr(8'h2a, 8'h00);
    cmp32(even_cycles, ovh(5) + 32'd129);
  endtask : t_internal
  task automatic t_dual_int;
    wr(8'h29, 8'h02);
    wr(8'h38, 8'h03);
    wr(8'h39, 8'h00);
    rd(8'h38, 8'h03);
    cmp32(odd_cycles, ovh(5) + 32'(129 * 3));
    cmp32(even_cycles, ovh(5) + 32'd129);
  endtask : t_dual_int
  task automatic t_external;
    wr(8'h29, 8'h01);
    ext(0, 1, ovh(5) + 32'd1, ovh(5) + 32'd1);
    wr(8'h27, 8'h00);
    rd(8'h27, 8'h00);
    wr(8'h29, 8'h03);
    ext(2, 5, ovh(5) + 32'd5, ovh(5) + 32'd3);
  endtask : t_external
  // A write issued while clk_en is low must not land
  task automatic t_freeze;
    clk_en <= 1'b0;
    wr(8'h49, 8'h07);
    clk_en <= 1'b1;
    rd(8'h49, 8'h05);
  endtask : t_freeze
  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_internal();
    t_dual_int();
    t_external();
    t_freeze();
    conclude();
  end
endmodule : tb_top
